/* File: bench/test_vme_master_rmw_tenure_exception.sv */
`timescale 1ns/1ps

// Drives the outbound master against the bus model and judges each scenario.
module test_vme_master_rmw_tenure_exception;
  localparam logic [63:0] TARGET = 64'h0000_0001_0000_0100;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] maskVal = 32'h0000_FFFF;
  logic [31:0] cmpVal = 32'h0000_1234;
  logic [31:0] swapVal = 32'h0000_ABCD;
  logic [31:0] initWord = 32'h5A5A_1234;
  logic [63:0] cmdAddr = 64'h0000_0000_0000_0000;
  logic [31:0] cmdWdata = 32'h0000_0000;
  logic [15:0] timeOnLimit = 16'h0008;
  logic [1:0] releaseMode = 2'h0;
  logic [1:0] faultKind = 2'h0;
  logic [1:0] cmdSize = vmr_pkg::SIZE_32;
  logic rmwEnable = 1'b1, cmdValid = 1'b0, cmdWrite = 1'b0, cmdTwoEdge = 1'b0;
  logic cmdWindowHit = 1'b1, faultAck = 1'b0, rivalReq = 1'b0;
  logic cmdReady, cplValid, cplError, wrFlush, busRequest, busGrant, busBusy;
  logic otherRequest, busClear, xferStart, xferWrite, xferDone, xferBusError;
  logic xferSlaveTerm, faultValid, faultOverflow, faultEvent, prevBusy;
  logic [63:0] xferAddr;
  logic [31:0] cplData, xferWdata, xferRdata, fault_addr_high, fault_addr_low, lastCpl;
  logic [7:0] fault_attributes;
  logic [1:0] xferSize;
  int badCount = 0, checksDone = 0, cycles = 0, starts = 0, events = 0, flushes = 0, falls = 0;

  vmr_master vmr_master_inst (.core_clk, .srst, .rmw_target_addr_high(TARGET[63:32]),
    .rmw_target_addr_low(TARGET[31:2]), .rmw_bit_mask(maskVal), .rmw_compare_value(cmpVal),
    .rmw_swap_value(swapVal), .rmwEnable, .timeOnLimit, .timeOffLimit(16'h0006), .releaseMode,
    .cmdValid, .cmdAddr, .cmdWrite, .cmdSize, .cmdTwoEdge, .cmdWindowHit, .cmdWdata,
    .cmdMore(1'b0), .cmdReady, .cplValid, .cplData, .cplError, .wrFlush, .busRequest,
    .busGrant, .busBusy, .otherRequest, .busClear, .xferStart, .xferWrite, .xferAddr,
    .xferWdata, .xferSize, .xferDone, .xferRdata, .xferBusError, .xferSlaveTerm, .faultAck,
    .fault_addr_high, .fault_addr_low, .fault_attributes, .faultValid, .faultOverflow,
    .faultEvent);
  vmr_bus_model vmr_bus_model_inst (.core_clk, .srst, .busRequest, .busGrant, .busClear,
    .otherRequest, .xferStart, .xferWrite, .xferWdata, .xferDone, .xferRdata, .xferBusError,
    .xferSlaveTerm, .rivalReq, .faultKind, .initWord);

  // Clock at 40 MHz.
  always #12.5 core_clk = ~core_clk;

  // Counts pulses, keeps the last completion and cuts a hang short.
  always @(posedge core_clk) begin
    cycles++;
    if (cplValid) lastCpl <= cplData;
    starts += int'(xferStart);
    events += int'(faultEvent);
    flushes += int'(wrFlush);
    if (prevBusy && !busBusy) falls++;
    prevBusy <= busBusy;
    if (cycles == 5000) begin
      badCount++;
      results();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checksDone++;
    if (seen !== want) begin
      badCount++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check

  // Holds a command until taken, then waits for its end and lets the bus settle.
  task automatic issue(input logic [63:0] addr, input logic wr, input logic two);
    int i;
    cmdAddr = addr;
    cmdWrite = wr;
    cmdTwoEdge = two;
    cmdValid = 1'b1;
    for (i = 0; i < 100 && cmdReady !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    cmdValid = 1'b0;
    for (i = 0; i < 200 && !(wr ? xferDone : cplValid); i++) @(negedge core_clk);
    repeat (20) @(negedge core_clk);
  endtask : issue

  // Near miss of the target, then a matching and a failing compare-and-swap.
  task automatic t_rmw();
    int s, f;
    s = starts;
    issue(TARGET + 64'h4, 1'b0, 1'b0);
    check(lastCpl, initWord);
    check(starts - s, 1);
    s = starts;
    f = falls;
    issue(TARGET, 1'b0, 1'b0);
    check(lastCpl, initWord);
    check(vmr_bus_model_inst.memWord, 32'h5A5A_ABCD);
    check(starts - s, 2);
    check(falls - f, 1);
    cmpVal = 32'h0000_5432;
    s = starts;
    issue(TARGET, 1'b0, 1'b0);
    check(lastCpl, 32'h5A5A_ABCD);
    check(vmr_bus_model_inst.memWord, 32'h5A5A_ABCD);
    check(starts - s, 2);
    check(xferAddr, TARGET);
    check(xferSize, vmr_pkg::SIZE_32);
    cmdWindowHit = 1'b0;
    s = starts;
    issue(TARGET, 1'b0, 1'b0);
    check(starts - s, 1);
    cmdWindowHit = 1'b1;
    cmdSize = vmr_pkg::SIZE_16;
    s = starts;
    issue(TARGET + 64'h1, 1'b0, 1'b0);
    check(starts - s, 1);
    check(xferSize, vmr_pkg::SIZE_16);
    cmdSize = vmr_pkg::SIZE_32;
  endtask : t_rmw

  // Bus error on a read, slave termination on a two-edge write, acknowledge.
  task automatic t_fault();
    int e, fl;
    e = events;
    fl = flushes;
    faultKind = 2'h1;
    issue(TARGET + 64'h8, 1'b0, 1'b0);
    check(lastCpl, vmr_pkg::ALL_ONES);
    check({fault_addr_high, fault_addr_low}, TARGET + 64'h8);
    check(fault_attributes, (8'h01 << vmr_pkg::ATTR_BERR_BIT) |
      ({6'h00, vmr_pkg::SIZE_32} << vmr_pkg::ATTR_SIZE_LSB));
    check(events - e, 1);
    faultKind = 2'h2;
    issue(TARGET + 64'hC, 1'b1, 1'b1);
    check(flushes - fl, 1);
    check(fault_addr_low, TARGET[31:0] + 32'h0000_0008);
    check(faultOverflow, 1'b1);
    faultAck = 1'b1;
    @(negedge core_clk);
    faultAck = 1'b0;
    @(negedge core_clk);
    check({faultValid, faultOverflow}, 2'b00);
    issue(TARGET + 64'h8, 1'b0, 1'b0);
    check(faultValid, 1'b0);
    faultKind = 2'h0;
  endtask : t_fault

  // Each release mode after a finished read, then with a rival requesting.
  task automatic t_modes();
    int m;
    for (m = 0; m < 4; m++) begin
      releaseMode = m[1:0];
      timeOnLimit = (m == 3) ? 16'h0100 : 16'h0008;
      issue(TARGET + 64'h10, 1'b0, 1'b0);
      check(busBusy, m == 3);
      rivalReq = 1'b1;
      repeat (20) @(negedge core_clk);
      check(busBusy, 1'b0);
      rivalReq = 1'b0;
    end
    timeOnLimit = 16'h0008;
    issue(TARGET + 64'h10, 1'b0, 1'b0);
    check(busBusy, 1'b0);
  endtask : t_modes

  task automatic results();
    if (badCount == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Reset for five cycles, then the scenarios in turn.
  initial begin
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    t_rmw();
    t_fault();
    t_modes();
    results();
  end
endmodule : test_vme_master_rmw_tenure_exception

/* File: bench/vmr_bus_model.sv */
`timescale 1ns/1ps

// Arbiter, rival master and one-word remote slave on the far side.
module vmr_bus_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Arbitration.
  input wire logic busRequest,
  output logic busGrant,
  output logic busClear,
  output logic otherRequest,
  // Transfers.
  input wire logic xferStart,
  input wire logic xferWrite,
  input wire logic [31:0] xferWdata,
  output logic xferDone,
  output logic [31:0] xferRdata,
  output logic xferBusError,
  output logic xferSlaveTerm,
  // Scenario controls.
  input wire logic rivalReq,
  input wire logic [1:0] faultKind,
  input wire logic [31:0] initWord
);
  logic [31:0] memWord;
  logic [3:0] waitCnt;
  logic busyXfer;

  // The rival is of higher priority, so the arbiter clears the bus for it.
  assign otherRequest = rivalReq;
  assign busClear = rivalReq;

  // Grant follows a request by one cycle; the slave answers four cycles after a start.
  always_ff @(posedge core_clk) begin
    busGrant <= !srst && busRequest;
    xferDone <= 1'b0;
    xferBusError <= 1'b0;
    xferSlaveTerm <= 1'b0;
    xferRdata <= ~xferRdata;
    if (srst) begin
      busyXfer <= 1'b0;
      memWord <= initWord;
      xferRdata <= 32'h0000_0000;
    end else if (xferStart) begin
      busyXfer <= 1'b1;
      waitCnt <= 4'h2;
    end else if (busyXfer && waitCnt == 4'h0) begin
      busyXfer <= 1'b0;
      xferDone <= 1'b1;
      xferBusError <= faultKind == 2'h1;
      xferSlaveTerm <= faultKind == 2'h2;
      xferRdata <= memWord;
      if (faultKind == 2'h0 && xferWrite) begin
        memWord <= xferWdata;
      end
    end else if (busyXfer) begin
      waitCnt <= waitCnt - 4'h1;
    end
  end
endmodule : vmr_bus_model

/* File: bench/vmr_master_sva.sv */
`timescale 1ns/1ps

// Watches the master's ports for arbitration, release and fault slips.
module vmr_master_chk (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Command and arbitration.
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [15:0] timeOffLimit,
  input wire logic busRequest,
  input wire logic busGrant,
  input wire logic busBusy,
  // Transfers and completions.
  input wire logic xferStart,
  input wire logic xferWrite,
  input wire logic xferDone,
  input wire logic xferBusError,
  input wire logic cplValid,
  input wire logic cplError,
  input wire logic [31:0] cplData,
  input wire logic wrFlush,
  // Exception status.
  input wire logic faultAck,
  input wire logic [31:0] fault_addr_low,
  input wire logic [7:0] fault_attributes,
  input wire logic faultValid,
  input wire logic faultOverflow,
  input wire logic faultEvent
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [16:0] offCnt_q;
  logic [16:0] offCnt_d;

  // Cycles spent off the bus; starts full so the first request needs no wait.
  always_comb begin
    offCnt_d = offCnt_q;
    if (busBusy) begin
      offCnt_d = 17'h0_0000;
    end else if (offCnt_q != 17'h1_FFFF) begin
      offCnt_d = offCnt_q + 17'h0_0001;
    end
  end
  always_ff @(posedge core_clk) begin
    offCnt_q <= srst ? 17'h1_FFFF : offCnt_d;
  end

  a_take_request:
    assert property (cmdValid && cmdReady && !busBusy && !busRequest |=> busRequest)
    else $error("no bus request after a command");
  a_grant_own:
    assert property (busRequest && busGrant |=> busBusy && !busRequest)
    else $error("grant did not give ownership");
  a_start_owned:
    assert property (xferStart |-> busBusy)
    else $error("transfer started without ownership");
  a_off_wait:
    assert property ($rose(busRequest) |-> offCnt_q >= {1'b0, timeOffLimit})
    else $error("bus requested again too soon");
  a_fail_ones:
    assert property (xferDone && xferBusError && !xferWrite |=>
      cplValid && cplError && cplData == vmr_pkg::ALL_ONES)
    else $error("failed read not completed with ones");
  a_write_flush:
    assert property (xferDone && xferBusError && xferWrite |=> wrFlush)
    else $error("failed write data not flushed");
  a_fault_event:
    assert property (xferDone && xferBusError |=> faultEvent && faultValid)
    else $error("bus error raised no exception event");
  a_status_hold:
    assert property (faultValid && !faultAck |=>
      faultValid && $stable(fault_addr_low) && $stable(fault_attributes))
    else $error("captured status changed before acknowledge");
  a_ack_clear:
    assert property (faultAck ##1 !faultEvent |-> !faultValid && !faultOverflow)
    else $error("acknowledge did not clear status");

  // Main scenarios reached.
  c_rmw_pair: cover property (xferStart && !xferWrite ##[1:40] xferStart && xferWrite);
  c_overflow: cover property (faultOverflow);
  c_release: cover property ($fell(busBusy));
endmodule : vmr_master_chk

bind vmr_master vmr_master_chk vmr_master_chk_inst (.core_clk, .srst, .cmdValid, .cmdReady,
  .timeOffLimit, .busRequest, .busGrant, .busBusy, .xferStart, .xferWrite, .xferDone,
  .xferBusError, .cplValid, .cplError, .cplData, .wrFlush, .faultAck, .fault_addr_low,
  .fault_attributes, .faultValid, .faultOverflow, .faultEvent);

/* File: core/vmr_fault_capture.sv */
`timescale 1ns/1ps

// Holds the status of the first failed transfer until software acknowledges it.
module vmr_fault_capture (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Failure report from the master sequencer.
  input wire logic failPulse,
  input wire logic [vmr_pkg::ADDR_W-1:0] failAddr,
  input wire logic [vmr_pkg::ATTR_W-1:0] failAttr,
  // Software acknowledge.
  input wire logic faultAck,
  // Captured status.
  output logic [31:0] fault_addr_high,
  output logic [31:0] fault_addr_low,
  output logic [vmr_pkg::ATTR_W-1:0] fault_attributes,
  output logic faultValid,
  output logic faultOverflow,
  output logic faultEvent
);

  logic [31:0] addrHigh_q, addrHigh_d;
  logic [31:0] addrLow_q, addrLow_d;
  logic [vmr_pkg::ATTR_W-1:0] attr_q, attr_d;
  logic valid_q, valid_d;
  logic ovf_q, ovf_d;
  logic event_q, event_d;

  // First failure loads the status; later ones flag overflow and leave it; every failure pulses the event; a failure wins over ack.
  always_comb begin
    addrHigh_d = addrHigh_q;
    addrLow_d = addrLow_q;
    attr_d = attr_q;
    valid_d = valid_q;
    ovf_d = ovf_q;
    event_d = 1'b0;
    if (faultAck) begin
      valid_d = 1'b0;
      ovf_d = 1'b0;
    end
    if (failPulse) begin
      if (valid_q && !faultAck) begin
        ovf_d = 1'b1;
      end else begin
        addrHigh_d = failAddr[63:32];
        addrLow_d = failAddr[31:0];
        attr_d = failAttr;
        valid_d = 1'b1;
      end
      event_d = 1'b1;
    end
  end

  // Status registers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addrHigh_q <= 32'h0000_0000;
      addrLow_q <= 32'h0000_0000;
      attr_q <= 8'h00;
      valid_q <= 1'b0;
      ovf_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      addrHigh_q <= addrHigh_d;
      addrLow_q <= addrLow_d;
      attr_q <= attr_d;
      valid_q <= valid_d;
      ovf_q <= ovf_d;
      event_q <= event_d;
    end
  end

  // Outputs come straight from the flip-flops.
  assign fault_addr_high = addrHigh_q;
  assign fault_addr_low = addrLow_q;
  assign fault_attributes = attr_q;
  assign faultValid = valid_q;
  assign faultOverflow = ovf_q;
  assign faultEvent = event_q;

endmodule : vmr_fault_capture

/* File: core/vmr_master.sv */
`timescale 1ns/1ps

// Contract
// - Read-modify-write only for naturally aligned 8, 16 or 32 bit transfers.
// - Keep the bus from the read-modify-write read through its write.
// - Target address held as high word 63:32 and low word 31:2.
// - Per-bit mask picks bits for both compare and swap.
// - Start only when host read address equals target inside an enabled window.
// - Compare returned data with compare value on masked bits only.
// - Matching enabled bits take swap value; other bits written back as read.
// - Host read completes with the original read data, not the swapped value.
// - Request bus on new command, or pending command after time-off expiry.
// - After release wait the time-off interval before requesting again.
// - Time-on timer bounds ownership; keep bus until release condition holds.
// - Mode 0 releases on time-on expiry or done.
// - Mode 1 releases on done, or expiry with another bus request.
// - Mode 2 releases on done, or expiry with bus clear asserted.
// - Mode 3 releases on expiry, or done with another request pending.
// - Failed transfer records address high, low and attributes.
// - Capture on bus error, or slave termination on two-edge transfer.
// - Exception flushes write data held for the failed transaction.
// - Failed read completes with all ones data.
// - Further exception before acknowledge keeps status and sets overflow.
// - Provide an event whenever exception status is updated.
module vmr_master (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Configuration.
  input wire logic [31:0] rmw_target_addr_high,
  input wire logic [29:0] rmw_target_addr_low,
  input wire logic [31:0] rmw_bit_mask,
  input wire logic [31:0] rmw_compare_value,
  input wire logic [31:0] rmw_swap_value,
  input wire logic rmwEnable,
  input wire logic [15:0] timeOnLimit,
  input wire logic [15:0] timeOffLimit,
  input wire logic [1:0] releaseMode,
  // Command from the internal linkage fabric.
  input wire logic cmdValid,
  input wire logic [63:0] cmdAddr,
  input wire logic cmdWrite,
  input wire logic [1:0] cmdSize,
  input wire logic cmdTwoEdge,
  input wire logic cmdWindowHit,
  input wire logic [31:0] cmdWdata,
  input wire logic cmdMore,
  output logic cmdReady,
  // Completion to the internal side.
  output logic cplValid,
  output logic [31:0] cplData,
  output logic cplError,
  output logic wrFlush,
  // Arbitration.
  output logic busRequest,
  input wire logic busGrant,
  output logic busBusy,
  input wire logic otherRequest,
  input wire logic busClear,
  // Data transfer engine on the bus.
  output logic xferStart,
  output logic xferWrite,
  output logic [63:0] xferAddr,
  output logic [31:0] xferWdata,
  output logic [1:0] xferSize,
  input wire logic xferDone,
  input wire logic [31:0] xferRdata,
  input wire logic xferBusError,
  input wire logic xferSlaveTerm,
  // Exception status.
  input wire logic faultAck,
  output logic [31:0] fault_addr_high,
  output logic [31:0] fault_addr_low,
  output logic [7:0] fault_attributes,
  output logic faultValid,
  output logic faultOverflow,
  output logic faultEvent
);

  // Alignment check used only by the read-modify-write address match.
  function automatic logic is_aligned(input logic [1:0] size, input logic [1:0] lsb);
    case (size)
      vmr_pkg::SIZE_8: is_aligned = 1'b1;
      vmr_pkg::SIZE_16: is_aligned = ~lsb[0];
      vmr_pkg::SIZE_32: is_aligned = (lsb == 2'h0);
      default: is_aligned = 1'b0;
    endcase
  endfunction : is_aligned

  vmr_pkg::vmr_state_type state_q, state_d;
  logic [15:0] onCnt_q, onCnt_d;
  logic [15:0] offCnt_q, offCnt_d;
  logic pend_q, pend_d;
  logic [63:0] addr_q, addr_d;
  logic wr_q, wr_d;
  logic [1:0] size_q, size_d;
  logic twoEdge_q, twoEdge_d;
  logic rmw_q, rmw_d;
  logic [31:0] wdata_q, wdata_d;
  logic rdy_q, rdy_d;
  logic xferWr_q, xferWr_d;
  logic more_q, more_d;
  logic busReq_q, busReq_d;
  logic busBusy_q, busBusy_d;
  logic start_q, start_d;
  logic cplValid_q, cplValid_d;
  logic [31:0] cplData_q, cplData_d;
  logic cplErr_q, cplErr_d;
  logic flush_q, flush_d;
  logic failPulse;
  logic [7:0] failAttr;
  logic onExpired;
  logic doneNow;
  logic releaseNow;
  logic rmwHit;
  logic failed;
  logic [31:0] matchBits;
  logic [31:0] mergedData;

  // Read-modify-write address match on an enabled outbound window.
  assign rmwHit = rmwEnable && cmdValid && !cmdWrite && cmdWindowHit
      && cmdAddr[63:32] == rmw_target_addr_high
      && cmdAddr[31:2] == rmw_target_addr_low
      && is_aligned(cmdSize, cmdAddr[1:0]);

  // Masked compare and per-bit merge; with no match the data goes back unchanged.
  assign matchBits = rmw_bit_mask & ~(xferRdata ^ rmw_compare_value);
  assign mergedData = (xferRdata & ~matchBits) | (rmw_swap_value & matchBits);

  // Release decision for the four modes.
  assign onExpired = (onCnt_q >= timeOnLimit);
  assign doneNow = !pend_q && !cmdValid && !more_q;
  always_comb begin
    case (releaseMode)
      vmr_pkg::REL_TIMER_OR_DONE: releaseNow = onExpired || doneNow;
      vmr_pkg::REL_TIMER_AND_REQ: releaseNow = doneNow || (onExpired && otherRequest);
      vmr_pkg::REL_TIMER_AND_CLR: releaseNow = doneNow || (onExpired && busClear);
      vmr_pkg::REL_TIMER_OR_DONE_REQ: releaseNow = onExpired || (doneNow && otherRequest);
      default: releaseNow = 1'b1;
    endcase
  end

  // Failure detection on the active transfer.
  assign failed = xferDone && (xferBusError || (twoEdge_q && xferSlaveTerm));
  assign failPulse = failed && (state_q == vmr_pkg::ST_XFER || state_q == vmr_pkg::ST_RMW_WR);
  always_comb begin
    failAttr = 8'h00;
    failAttr[vmr_pkg::ATTR_WRITE_BIT] = wr_q || state_q == vmr_pkg::ST_RMW_WR;
    failAttr[vmr_pkg::ATTR_SIZE_LSB +: 2] = size_q;
    failAttr[vmr_pkg::ATTR_TWO_EDGE_BIT] = twoEdge_q;
    failAttr[vmr_pkg::ATTR_BERR_BIT] = xferBusError;
    failAttr[vmr_pkg::ATTR_RMW_BIT] = rmw_q;
  end

  // Master sequencer: arbitration, tenure timers, transfers and completions.
  always_comb begin
    state_d = state_q;
    onCnt_d = onCnt_q;
    offCnt_d = offCnt_q;
    pend_d = pend_q;
    addr_d = addr_q;
    wr_d = wr_q;
    size_d = size_q;
    twoEdge_d = twoEdge_q;
    rmw_d = rmw_q;
    wdata_d = wdata_q;
    more_d = more_q;
    busReq_d = busReq_q;
    busBusy_d = busBusy_q;
    start_d = 1'b0;
    cplValid_d = 1'b0;
    cplData_d = cplData_q;
    cplErr_d = 1'b0;
    flush_d = 1'b0;
    if (busBusy_q && onCnt_q != 16'hFFFF) begin
      onCnt_d = onCnt_q + 16'h0001;
    end
    // Latch a new command only when none is held.
    if (cmdValid && rdy_q) begin
      pend_d = 1'b1;
      addr_d = cmdAddr;
      wr_d = cmdWrite;
      size_d = cmdSize;
      twoEdge_d = cmdTwoEdge;
      rmw_d = rmwHit;
      wdata_d = cmdWdata;
      more_d = cmdMore;
    end
    case (state_q)
      vmr_pkg::ST_IDLE: begin
        if ((cmdValid && rdy_q) || pend_q) begin
          busReq_d = 1'b1;
          state_d = vmr_pkg::ST_REQ;
        end
      end
      vmr_pkg::ST_REQ: begin
        if (busGrant) begin
          busReq_d = 1'b0;
          busBusy_d = 1'b1;
          onCnt_d = vmr_pkg::TIMER_RESET;
          state_d = vmr_pkg::ST_OWN;
        end
      end
      vmr_pkg::ST_OWN: begin
        if (pend_q && !(releaseNow && !doneNow)) begin
          start_d = 1'b1;
          state_d = vmr_pkg::ST_XFER;
        end else if (releaseNow) begin
          busBusy_d = 1'b0;
          offCnt_d = vmr_pkg::TIMER_RESET;
          state_d = vmr_pkg::ST_OFF;
        end
      end
      vmr_pkg::ST_XFER: begin
        if (xferDone) begin
          if (failed) begin
            pend_d = 1'b0;
            flush_d = wr_q;
            cplValid_d = !wr_q;
            cplData_d = vmr_pkg::ALL_ONES;
            cplErr_d = 1'b1;
            state_d = vmr_pkg::ST_OWN;
          end else if (rmw_q && !wr_q) begin
            cplValid_d = 1'b1;
            cplData_d = xferRdata;
            wdata_d = mergedData;
            start_d = 1'b1;
            state_d = vmr_pkg::ST_RMW_WR;
          end else begin
            pend_d = 1'b0;
            cplValid_d = !wr_q;
            cplData_d = xferRdata;
            state_d = vmr_pkg::ST_OWN;
          end
        end
      end
      vmr_pkg::ST_RMW_WR: begin
        if (xferDone) begin
          pend_d = 1'b0;
          flush_d = failed;
          state_d = vmr_pkg::ST_OWN;
        end
      end
      vmr_pkg::ST_OFF: begin
        offCnt_d = offCnt_q + 16'h0001;
        if (offCnt_q >= timeOffLimit) begin
          state_d = vmr_pkg::ST_IDLE;
        end
      end
      default: state_d = vmr_pkg::ST_IDLE;
    endcase
    rdy_d = !pend_d && (state_d == vmr_pkg::ST_IDLE || state_d == vmr_pkg::ST_OWN);
    xferWr_d = wr_d || state_d == vmr_pkg::ST_RMW_WR;
  end

  // Sequencer registers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= vmr_pkg::ST_IDLE;
      onCnt_q <= vmr_pkg::TIMER_RESET;
      offCnt_q <= vmr_pkg::TIMER_RESET;
      pend_q <= 1'b0;
      addr_q <= 64'h0000_0000_0000_0000;
      wr_q <= 1'b0;
      size_q <= vmr_pkg::SIZE_8;
      twoEdge_q <= 1'b0;
      rmw_q <= 1'b0;
      wdata_q <= vmr_pkg::DATA_RESET;
      rdy_q <= 1'b0;
      xferWr_q <= 1'b0;
      more_q <= 1'b0;
      busReq_q <= 1'b0;
      busBusy_q <= 1'b0;
      start_q <= 1'b0;
      cplValid_q <= 1'b0;
      cplData_q <= vmr_pkg::DATA_RESET;
      cplErr_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      state_q <= state_d;
      onCnt_q <= onCnt_d;
      offCnt_q <= offCnt_d;
      pend_q <= pend_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      size_q <= size_d;
      twoEdge_q <= twoEdge_d;
      rmw_q <= rmw_d;
      wdata_q <= wdata_d;
      rdy_q <= rdy_d;
      xferWr_q <= xferWr_d;
      more_q <= more_d;
      busReq_q <= busReq_d;
      busBusy_q <= busBusy_d;
      start_q <= start_d;
      cplValid_q <= cplValid_d;
      cplData_q <= cplData_d;
      cplErr_q <= cplErr_d;
      flush_q <= flush_d;
    end
  end

  // Registered outputs.
  assign cmdReady = rdy_q;
  assign busRequest = busReq_q;
  assign busBusy = busBusy_q;
  assign xferStart = start_q;
  assign xferWrite = xferWr_q;
  assign xferAddr = addr_q;
  assign xferWdata = wdata_q;
  assign xferSize = size_q;
  assign cplValid = cplValid_q;
  assign cplData = cplData_q;
  assign cplError = cplErr_q;
  assign wrFlush = flush_q;

  // Exception status capture.
  vmr_fault_capture vmr_fault_capture_inst (
    .core_clk(core_clk),
    .srst(srst),
    .failPulse(failPulse),
    .failAddr(addr_q),
    .failAttr(failAttr),
    .faultAck(faultAck),
    .fault_addr_high(fault_addr_high),
    .fault_addr_low(fault_addr_low),
    .fault_attributes(fault_attributes),
    .faultValid(faultValid),
    .faultOverflow(faultOverflow),
    .faultEvent(faultEvent)
  );

endmodule : vmr_master

/* File: core/vmr_pkg.sv */
package vmr_pkg;

  // Data and address widths of the outbound master path.
  localparam int DATA_W = 32;
  localparam int ADDR_W = 64;
  localparam int TIMER_W = 16;

  // Transfer size codes carried with each command.
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  // Release mode codes.
  localparam logic [1:0] REL_TIMER_OR_DONE = 2'h0;
  localparam logic [1:0] REL_TIMER_AND_REQ = 2'h1;
  localparam logic [1:0] REL_TIMER_AND_CLR = 2'h2;
  localparam logic [1:0] REL_TIMER_OR_DONE_REQ = 2'h3;

  // Field positions inside the captured attribute word.
  localparam int ATTR_WRITE_BIT = 0;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_TWO_EDGE_BIT = 3;
  localparam int ATTR_BERR_BIT = 4;
  localparam int ATTR_RMW_BIT = 5;
  localparam int ATTR_W = 8;

  // Reset values, and the all-ones fill for failed reads.
  localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ALL_ONES = 32'hFFFF_FFFF;

  // Master sequencing states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_OWN = 3'b010,
    ST_XFER = 3'b011,
    ST_RMW_WR = 3'b100,
    ST_OFF = 3'b101
  } vmr_state_type;

endpackage : vmr_pkg
